// File: common/ecd_pkg.sv
// package with register map, field layout, reset values and ramp constants
package ecd_pkg;
  localparam int NUM_CH = 8;
  localparam int WORD_W = 16;
  localparam int RW_BIT = 15;
  localparam int IDX_MSB = 14;
  localparam int IDX_LSB = 8;
  localparam logic [6:0] IDX_ATT1 = 7'h01;
  localparam logic [6:0] IDX_ATT6 = 7'h06;
  localparam logic [6:0] IDX_MUTE_LO = 7'h07;
  localparam logic [6:0] IDX_DIS_LO = 7'h08;
  localparam logic [6:0] IDX_FMT = 7'h09;
  localparam logic [6:0] IDX_DEEMPH = 7'h0a;
  localparam logic [6:0] IDX_RDPTR = 7'h0b;
  localparam logic [6:0] IDX_GPO = 7'h0c;
  localparam logic [6:0] IDX_ATT7 = 7'h10;
  localparam logic [6:0] IDX_ATT8 = 7'h11;
  localparam logic [6:0] IDX_MUTE_HI = 7'h12;
  localparam logic [6:0] IDX_DIS_HI = 7'h13;
  localparam logic [7:0] ATT_RESET = 8'hff;
  localparam logic [7:0] ATT_MUTE_MAX = 8'h80;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] RDPTR_RESET = 8'h01;
  localparam logic [7:0] LO_MASK = 8'h3f;
  localparam logic [7:0] HI_MASK = 8'h03;
  localparam logic [7:0] R9_MASK = 8'h3f;
  localparam logic [7:0] R10_MASK = 8'h7f;
  localparam int STEP_SAMPLES = 8;
  localparam int CNT_W = 3;
  // control word split into its fields
  typedef struct packed {
    logic rd;
    logic [6:0] index;
    logic [7:0] data;
  } ecd_word_t;
  // decoded mode outputs
  typedef struct packed {
    logic filter_rolloff_slow;
    logic sysclk_out_half_rate;
    logic sysclk_out_disable;
    logic [2:0] audio_format_select;
    logic zero_flag_polarity;
    logic output_phase_invert;
    logic [1:0] deemph_rate_select;
    logic deemph_enable;
    logic seq_read_enable;
    logic [6:0] read_pointer;
    logic rate_select;
    logic gp_output_select;
    logic [5:0] general_purpose_outputs;
  } ecd_mode_t;
endpackage

// File: src/ecd_regs.sv
// mode register bank with per-channel attenuation ramps
// Contract
// - bit 15 selects read when one, bits 14:8 carry the register index
// - eight-bit attenuation per channel at indexes 1-6, 16, 17
// - attenuation registers reset to all ones, no attenuation
// - codes above 128 give half of code minus 255 decibels
// - codes 0 through 128 mean mute
// - applied level moves one step per eight sample periods to target
// - soft mute bits in index 7 bits 5:0, index 18 bits 1:0
// - setting mute ramps applied level down to mute stepwise
// - clearing mute ramps level back up to programmed code
// - output disable bits in index 8 and 19, one selects common mode
// - index 9 and 10 byte layouts as listed
// - index 11 pointer and sequential read, index 12 rate and gp outputs
// - de-emphasis on when any of three enable bits set
module ecd_regs
  import ecd_pkg::*;
#(
  parameter int CHANNELS = NUM_CH,
  parameter int STEP_PERIODS = STEP_SAMPLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic sample_tick_i,
  input wire logic word_valid_i,
  input wire logic [WORD_W-1:0] word_i,
  output logic [7:0] read_data_o,
  output logic read_valid_o,
  output logic [CHANNELS*8-1:0] applied_code_o,
  output logic [CHANNELS-1:0] channel_muted_o,
  output logic [CHANNELS-1:0] channel_output_disable_o,
  output ecd_mode_t mode_o
);

  ecd_word_t cmd;
  logic [7:0] att_reg [CHANNELS];
  logic [7:0] cur_reg [CHANNELS];
  logic [CHANNELS-1:0] soft_silence_bit_reg;
  logic [CHANNELS-1:0] disable_reg;
  logic [7:0] r9_reg;
  logic [7:0] r10_reg;
  logic [7:0] r11_reg;
  logic [7:0] r12_reg;
  logic [CNT_W-1:0] tick_cnt_reg;
  logic step_now;
  logic wr;

  // map a register index to its channel; returns CHANNELS when none
  function automatic int att_channel(input logic [6:0] idx);
    if (idx >= IDX_ATT1 && idx <= IDX_ATT6) begin
      return int'(idx - IDX_ATT1);
    end else if (idx == IDX_ATT7) begin
      return 6;
    end else if (idx == IDX_ATT8) begin
      return 7;
    end
    return CHANNELS;
  endfunction

  assign cmd = ecd_word_t'(word_i);
  assign wr = word_valid_i && !cmd.rd;

  // attenuation code registers
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < CHANNELS; i++) begin
        att_reg[i] <= ATT_RESET;
      end
    end else if (wr && att_channel(cmd.index) < CHANNELS) begin
      att_reg[att_channel(cmd.index)] <= cmd.data;
    end
  end

  // mute and output-disable bits
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      soft_silence_bit_reg <= '0;
      disable_reg <= '0;
    end else if (wr) begin
      case (cmd.index)
        IDX_MUTE_LO: soft_silence_bit_reg[5:0] <= cmd.data[5:0];
        IDX_MUTE_HI: soft_silence_bit_reg[7:6] <= cmd.data[1:0];
        IDX_DIS_LO: disable_reg[5:0] <= cmd.data[5:0];
        IDX_DIS_HI: disable_reg[7:6] <= cmd.data[1:0];
        default: ;
      endcase
    end
  end

  // mode registers; reserved test bits are not stored
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      r9_reg <= BYTE_ZERO;
      r10_reg <= BYTE_ZERO;
      r11_reg <= RDPTR_RESET;
      r12_reg <= BYTE_ZERO;
    end else if (wr) begin
      case (cmd.index)
        IDX_FMT: r9_reg <= cmd.data & R9_MASK;
        IDX_DEEMPH: r10_reg <= cmd.data & R10_MASK;
        IDX_RDPTR: r11_reg <= cmd.data;
        IDX_GPO: r12_reg <= cmd.data;
        default: ;
      endcase
    end
  end

  // shared divider: one ramp step every eight sample ticks
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tick_cnt_reg <= '0;
    end else if (sample_tick_i) begin
      tick_cnt_reg <= (tick_cnt_reg == CNT_W'(STEP_PERIODS - 1)) ? '0 : tick_cnt_reg + 1'b1;
    end
  end
  assign step_now = sample_tick_i && (tick_cnt_reg == CNT_W'(STEP_PERIODS - 1));

  // per-channel ramp; mute range is collapsed to 128 so stepping stays 0.5 dB
  for (genvar c = 0; c < CHANNELS; c++) begin : g_ramp
    logic [7:0] target;
    always_comb begin
      if (soft_silence_bit_reg[c] || att_reg[c] <= ATT_MUTE_MAX) begin
        target = ATT_MUTE_MAX;
      end else begin
        target = att_reg[c];
      end
    end
    always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
        cur_reg[c] <= ATT_RESET;
      end else if (step_now) begin
        if (cur_reg[c] < target) begin
          cur_reg[c] <= cur_reg[c] + 8'h01;
        end else if (cur_reg[c] > target) begin
          cur_reg[c] <= cur_reg[c] - 8'h01;
        end
      end
    end
    // code maps to 0.5*(code-255) dB downstream
    assign applied_code_o[c*8 +: 8] = cur_reg[c];
    assign channel_muted_o[c] = cur_reg[c] <= ATT_MUTE_MAX;
  end

  assign channel_output_disable_o = disable_reg;

  always_comb begin
    mode_o.filter_rolloff_slow = r9_reg[5];
    mode_o.sysclk_out_half_rate = r9_reg[4];
    mode_o.sysclk_out_disable = r9_reg[3];
    mode_o.audio_format_select = r9_reg[2:0];
    mode_o.zero_flag_polarity = r10_reg[6];
    mode_o.output_phase_invert = r10_reg[5];
    mode_o.deemph_rate_select = r10_reg[4:3];
    mode_o.deemph_enable = |r10_reg[2:0];
    mode_o.seq_read_enable = r11_reg[7];
    mode_o.read_pointer = r11_reg[6:0];
    mode_o.rate_select = r12_reg[7];
    mode_o.gp_output_select = r12_reg[6];
    mode_o.general_purpose_outputs = r12_reg[5:0];
  end

  // read path; unmapped and factory indexes return zero
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      read_data_o <= BYTE_ZERO;
      read_valid_o <= 1'b0;
    end else begin
      read_valid_o <= word_valid_i && cmd.rd;
      if (word_valid_i && cmd.rd) begin
        if (att_channel(cmd.index) < CHANNELS) begin
          read_data_o <= att_reg[att_channel(cmd.index)];
        end else begin
          case (cmd.index)
            IDX_MUTE_LO: read_data_o <= {2'b00, soft_silence_bit_reg[5:0]};
            IDX_MUTE_HI: read_data_o <= {6'b000000, soft_silence_bit_reg[7:6]};
            IDX_DIS_LO: read_data_o <= {2'b00, disable_reg[5:0]};
            IDX_DIS_HI: read_data_o <= {6'b000000, disable_reg[7:6]};
            IDX_FMT: read_data_o <= r9_reg;
            IDX_DEEMPH: read_data_o <= r10_reg;
            IDX_RDPTR: read_data_o <= r11_reg;
            IDX_GPO: read_data_o <= r12_reg;
            default: read_data_o <= BYTE_ZERO;
          endcase
        end
      end
    end
  end

endmodule

// File: verification/ecd_regs_assertions.sv
// port checker for the mode register bank
module ecd_regs_checker
  import ecd_pkg::*;
#(
  parameter int CHANNELS = NUM_CH,
  parameter int STEP_PERIODS = STEP_SAMPLES
) (
  input logic clk_i,
  input logic rst_i,
  input logic sample_tick_i,
  input logic word_valid_i,
  input logic [WORD_W-1:0] word_i,
  input logic [7:0] read_data_o,
  input logic read_valid_o,
  input logic [CHANNELS*8-1:0] applied_code_o,
  input logic [CHANNELS-1:0] channel_muted_o,
  input logic [CHANNELS-1:0] channel_output_disable_o,
  input ecd_mode_t mode_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic wr;
  assign wr = word_valid_i && !word_i[RW_BIT];
  rd_answer_a: assert property (word_valid_i && word_i[RW_BIT] |=> read_valid_o)
    else $error("read not answered");
  wr_quiet_a: assert property (wr |=> !read_valid_o) else $error("write answered");
  muted_map_a: assert property (channel_muted_o[0] == (applied_code_o[7:0] == ATT_MUTE_MAX)
    && applied_code_o[7:0] >= ATT_MUTE_MAX) else $error("mute flag wrong");
  tick_only_a: assert property (!sample_tick_i |=> $stable(applied_code_o))
    else $error("ramp moved off tick");
  one_step_a: assert property (!$stable(applied_code_o[7:0]) |->
    (applied_code_o[7:0] - $past(applied_code_o[7:0])) inside {8'h01, 8'hff}) else $error("step");
  dis_write_a: assert property (wr && word_i[14:8] == IDX_DIS_LO |=>
    channel_output_disable_o[5:0] == $past(word_i[5:0])) else $error("disable bits");
  fmt_write_a: assert property (wr && word_i[14:8] == IDX_FMT |=>
    mode_o.audio_format_select == $past(word_i[2:0])) else $error("format field");
  deemph_or_a: assert property (wr && word_i[14:8] == IDX_DEEMPH |=>
    mode_o.deemph_enable == $past(|word_i[2:0])) else $error("deemphasis enable");
  cover property (read_valid_o);
  cover property (channel_muted_o[0]);
  cover property (mode_o.deemph_enable);
endmodule
bind ecd_regs ecd_regs_checker #(.CHANNELS(CHANNELS), .STEP_PERIODS(STEP_PERIODS))
  i_ecd_regs_checker (.clk_i(clk_i), .rst_i(rst_i), .sample_tick_i(sample_tick_i),
  .word_valid_i(word_valid_i), .word_i(word_i), .read_data_o(read_data_o),
  .read_valid_o(read_valid_o), .applied_code_o(applied_code_o),
  .channel_muted_o(channel_muted_o), .channel_output_disable_o(channel_output_disable_o),
  .mode_o(mode_o));

// File: verification/ecd_host_model.sv
// host model that hands control words to the bank
module ecd_host_model
  import ecd_pkg::*;
(
  input logic clk_i,
  output logic word_valid_o,
  output ecd_word_t word_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial word_valid_o = 1'b0;
  initial word_o = 16'h0000;
  // caller keeps to mapped indexes and zeroed test bits
  task automatic send(input ecd_word_t w, input logic [1:0] gap);
    repeat (gap + 1) @(negedge clk_i);
    word_valid_o = 1'b1;
    word_o = w;
    @(negedge clk_i);
    word_valid_o = 1'b0;
    // released word shows the inverse so stale data cannot pass
    word_o = ~w;
  endtask
endmodule

// File: verification/ecd_regs_tb.sv
// self-checking bench for the mode register bank
module ecd_regs_tb
  import ecd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [6:0] IDX_ATT2 = 7'h02;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic sample_tick_i = 1'b0;
  logic word_valid_i;
  ecd_word_t word_i;
  logic [7:0] read_data_o;
  logic read_valid_o;
  logic [63:0] applied_code_o;
  logic [7:0] channel_muted_o;
  logic [7:0] channel_output_disable_o;
  ecd_mode_t mode_o;
  int mismatches = 0;
  int num_checks = 0;
  logic [7:0] rnd = 8'h12;
  logic [7:0] exp_q[$];
  logic [7:0] rst_t[16] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h01, 8'h00, 8'hff, 8'hff, 8'h00, 8'h00};
  logic [7:0] msk_t[16] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h3f, 8'h3f,
    8'h3f, 8'h7f, 8'hff, 8'hff, 8'hff, 8'hff, 8'h03, 8'h03};
  ecd_regs i_ecd_regs (.clk_i(clk_i), .rst_i(rst_i), .sample_tick_i(sample_tick_i),
    .word_valid_i(word_valid_i), .word_i(word_i), .read_data_o(read_data_o),
    .read_valid_o(read_valid_o), .applied_code_o(applied_code_o),
    .channel_muted_o(channel_muted_o), .channel_output_disable_o(channel_output_disable_o),
    .mode_o(mode_o));
  ecd_host_model i_ecd_host_model (.clk_i(clk_i), .word_valid_o(word_valid_i), .word_o(word_i));
  initial forever #5 clk_i = ~clk_i;
  always @(negedge clk_i) sample_tick_i <= ~sample_tick_i;
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    if (mismatches == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic wr(input logic [6:0] idx, input logic [7:0] d);
    rnd = lfsr(rnd);
    i_ecd_host_model.send({1'b0, idx, d}, rnd[1:0]);
  endtask
  task automatic rd(input logic [6:0] idx, input logic [7:0] e);
    exp_q.push_back(e);
    i_ecd_host_model.send({1'b1, idx, 8'h00}, 2'h0);
  endtask
  // ramps take up to 127 steps of 16 cycles
  task automatic wait_code(input int ch, input logic [7:0] e);
    int n;
    for (n = 0; n < 4000 && applied_code_o[ch*8 +: 8] !== e; n++) @(negedge clk_i);
    check(applied_code_o[ch*8 +: 8], e);
    if (n == 4000) stop_test();
  endtask
  always @(negedge clk_i) if (read_valid_o === 1'b1 && exp_q.size() > 0)
    check(read_data_o, exp_q.pop_front());
  initial begin
    logic [7:0] d;
    repeat (12) @(negedge clk_i);
    rst_i = 1'b0;
    for (int i = 0; i < 16; i++) rd(7'(i < 12 ? i + 1 : i + 4), rst_t[i]);
    wr(IDX_ATT1, 8'h82);
    wr(IDX_ATT7, 8'hfe);
    wait_code(6, 8'hfe);
    wait_code(0, 8'h82);
    wr(IDX_MUTE_LO, 8'h01);
    wait_code(0, 8'h80);
    check({7'h00, channel_muted_o[0]}, 8'h01);
    wr(IDX_MUTE_LO, 8'h00);
    wait_code(0, 8'h82);
    wr(IDX_ATT2, 8'h05);
    wait_code(1, 8'h80);
    for (int i = 0; i < 16; i++) begin
      rnd = lfsr(rnd);
      d = rnd & msk_t[i];
      wr(7'(i < 12 ? i + 1 : i + 4), d);
      rd(7'(i < 12 ? i + 1 : i + 4), d);
    end
    wr(IDX_DIS_HI, 8'h02);
    check({6'h00, channel_output_disable_o[7:6]}, 8'h02);
    wr(IDX_DEEMPH, 8'h04);
    check({7'h00, mode_o.deemph_enable}, 8'h01);
    wr(IDX_DEEMPH, 8'h00);
    check({7'h00, mode_o.deemph_enable}, 8'h00);
    repeat (4) @(negedge clk_i);
    stop_test();
  end
endmodule
